/* File: design/ros_pkg.sv */
// Purpose: shared constants for the real-time output steering block
// Assumes: 8-bit registers on a plain address/strobe port
// Notes: offsets and the cutoff register layout are local choices
package ros_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_SRC_SEL = 4'h0;
  localparam logic [3:0] ADDR_OUT_LOW = 4'h1;
  localparam logic [3:0] ADDR_OUT_HIGH = 4'h2;
  localparam logic [3:0] ADDR_CUT_ENA = 4'h3;
  localparam logic [3:0] ADDR_CUT_STATE = 4'h4;
  localparam logic [3:0] ADDR_CUT_STAT = 4'h5;
  localparam logic [3:0] ADDR_MOD_CTRL = 4'h6;
  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;
  localparam int BIT_CLEAR = 0;
  localparam int BIT_FLAG = 1;
  localparam int BIT_MOD_EN = 0;
  // cutoff state field codes
  localparam logic [1:0] CUT_HIZ = 2'h0;
  localparam logic [1:0] CUT_LOW = 2'h1;
  localparam logic [1:0] CUT_HIGH = 2'h2;
  localparam logic [1:0] CUT_OFF = 2'h3;
  // trigger edge selection codes
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

/* File: design/ros_steer.sv */
// Purpose: route timer waveforms onto eight motor phase outputs
// Assumes: waveform and trigger inputs synchronous to ref_clk
// Notes: disabled pins drive their inversion bit; cutoff groups are 2:0,6,5:3,7
`timescale 1ns/1ps
module ros_steer (
  input wire logic ref_clk, // 200 MHz clock
  input wire logic resetn, // synchronous reset, active low
  input wire logic [3:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic pwm_ch1, // timer channel 1 waveform
  input wire logic pwm_ch3, // timer channel 3 waveform
  input wire logic external_interrupt_input_0, // cutoff trigger
  output logic [7:0] motor_phase_output, // pin output value
  output logic [7:0] motor_phase_oe // pin output enable
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] src_q, src_d;
  logic [7:0] low_q, low_d;
  logic [7:0] high_q, high_d;
  logic [7:0] cena_q, cena_d;
  logic [7:0] cstate_q, cstate_d;
  logic [1:0] edge_q, edge_d;
  logic mod_en_q, mod_en_d;
  logic flag_q, flag_d;
  logic trig_q;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] out_q, out_d;
  logic [7:0] oe_q, oe_d;

  // map pin index to its two-bit cutoff state field
  function automatic logic [1:0] field_of(input logic [7:0] cs,
                                          input int n);
    logic [1:0] f;
    f = cs[1:0];
    if (n == 6) begin
      f = cs[3:2];
    end else if (n == 7) begin
      f = cs[7:6];
    end else if (n >= 3) begin
      f = cs[5:4];
    end
    return f;
  endfunction

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  // strobes last one cycle, so a plain compare per offset is
  // enough; unmapped offsets fall through to nothing
  wire wr_src = reg_wr && reg_addr == ros_pkg::ADDR_SRC_SEL;
  wire wr_low = reg_wr && reg_addr == ros_pkg::ADDR_OUT_LOW;
  wire wr_high = reg_wr && reg_addr == ros_pkg::ADDR_OUT_HIGH;
  wire wr_cena = reg_wr && reg_addr == ros_pkg::ADDR_CUT_ENA;
  wire wr_cst = reg_wr && reg_addr == ros_pkg::ADDR_CUT_STATE;
  wire wr_stat = reg_wr && reg_addr == ros_pkg::ADDR_CUT_STAT;
  wire wr_mod = reg_wr && reg_addr == ros_pkg::ADDR_MOD_CTRL;
  // clear request
  // only honoured while the flag is up, as software is told to do
  wire clr_req = wr_stat && reg_wdata[ros_pkg::BIT_CLEAR] && flag_q;

  // ----------------------------------------------------------------
  // trigger edge detection
  // ----------------------------------------------------------------
  // trigger edge
  // edge polarity chosen in module control bits 2:1
  // trig_q resets low; a level already high at release looks
  // like a rise, but the disabled module cannot set the flag
  wire rise = external_interrupt_input_0 && !trig_q;
  wire fall = !external_interrupt_input_0 && trig_q;
  wire trig_edge = (rise && edge_q[0]) || (fall && edge_q[1]);

  // register next values; writes ignored while disabled
  // a module control write always lands, so software can
  // re-enable a block that everything else ignores
  always_comb begin
    mod_en_d = wr_mod ? reg_wdata[ros_pkg::BIT_MOD_EN] : mod_en_q;
    edge_d = wr_mod ? reg_wdata[2:1] : edge_q;
    src_d = (wr_src && mod_en_q) ? reg_wdata : src_q;
    low_d = (wr_low && mod_en_q) ? reg_wdata : low_q;
    high_d = (wr_high && mod_en_q) ? reg_wdata : high_q;
    cena_d = (wr_cena && mod_en_q) ? reg_wdata : cena_q;
    cstate_d = (wr_cst && mod_en_q) ? reg_wdata : cstate_q;
    // flag set
    // a trigger in the clear cycle wins over the clear
    flag_d = flag_q;
    if (clr_req) begin
      flag_d = 1'b0;
    end
    if (trig_edge && mod_en_q) begin
      flag_d = 1'b1;
    end
    // held initialized
    // keyed on the next enable, so the disabling write clears
    // the registers and the flag at the same edge
    if (!mod_en_d) begin
      src_d = ros_pkg::RST_REG;
      low_d = ros_pkg::RST_REG;
      high_d = ros_pkg::RST_REG;
      cena_d = ros_pkg::RST_REG;
      cstate_d = ros_pkg::RST_REG;
      flag_d = 1'b0;
    end
  end

  // read mux, data appear the cycle after the strobe
  // zero outside the read slot keeps the bus quiet between reads
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ros_pkg::ADDR_SRC_SEL: rdata_d = src_q;
        ros_pkg::ADDR_OUT_LOW: rdata_d = low_q;
        ros_pkg::ADDR_OUT_HIGH: rdata_d = high_q;
        ros_pkg::ADDR_CUT_ENA: rdata_d = cena_q;
        ros_pkg::ADDR_CUT_STATE: rdata_d = cstate_q;
        // clear bit reads as zero
        ros_pkg::ADDR_CUT_STAT: rdata_d = {6'h00, flag_q, 1'b0};
        ros_pkg::ADDR_MOD_CTRL: rdata_d = {5'h00, edge_q, mod_en_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // output steering
  // ----------------------------------------------------------------
  // cutoff overrides the steered level pin by pin; the module
  // enable gates everything last so a disabled block stays quiet
  always_comb begin
    logic wave;
    logic en;
    logic inv;
    logic [1:0] fld;
    wave = 1'b0;
    en = 1'b0;
    inv = 1'b0;
    fld = ros_pkg::CUT_OFF;
    out_d = 8'h00;
    oe_d = 8'h00;
    for (int n = 0; n < 8; n++) begin
      // source select
      // zero picks channel 1, one picks channel 3
      wave = src_q[n] ? pwm_ch3 : pwm_ch1;
      // enable bits
      // two-bit index keeps every select in range for all pins
      en = (n < 4) ? low_q[n[1:0]] : high_q[n[1:0]];
      inv = (n < 4) ? low_q[{1'b1, n[1:0]}] : high_q[{1'b1, n[1:0]}];
      // disabled pin holds its inverted idle level
      out_d[n] = en ? (wave ^ inv) : inv;
      oe_d[n] = mod_en_q;
      fld = field_of(cstate_q, n);
      if (flag_q && cena_q[n] && fld != ros_pkg::CUT_OFF) begin
        out_d[n] = (fld == ros_pkg::CUT_HIGH);
        oe_d[n] = (fld != ros_pkg::CUT_HIZ);
      end
    end
    if (!mod_en_q) begin
      out_d = 8'h00;
      oe_d = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // flip-flops
  // ----------------------------------------------------------------
  // one synchronous reset for every register, constants only,
  // so the block leaves reset in a single known state
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      src_q <= ros_pkg::RST_REG;
      low_q <= ros_pkg::RST_REG;
      high_q <= ros_pkg::RST_REG;
      cena_q <= ros_pkg::RST_REG;
      cstate_q <= ros_pkg::RST_REG;
      edge_q <= ros_pkg::EDGE_RISE;
      mod_en_q <= 1'b0;
      flag_q <= 1'b0;
      trig_q <= 1'b0;
      rdata_q <= 8'h00;
      out_q <= 8'h00;
      oe_q <= 8'h00;
    end else begin
      src_q <= src_d;
      low_q <= low_d;
      high_q <= high_d;
      cena_q <= cena_d;
      cstate_q <= cstate_d;
      edge_q <= edge_d;
      mod_en_q <= mod_en_d;
      flag_q <= flag_d;
      trig_q <= external_interrupt_input_0;
      rdata_q <= rdata_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  // outputs come straight from flip-flops, free of decode glitches
  assign reg_rdata = rdata_q;
  assign motor_phase_output = out_q;
  assign motor_phase_oe = oe_q;
endmodule

/* File: verification/ros_steer_assertions.sv */
// Purpose: port checks for ros_steer
// Assumes: shadows follow register writes
// Notes: cutoff shadows clear while disabled, so checks only weaken
`timescale 1ns/1ps
module ros_steer_chk (
  input wire logic ref_clk, // clock
  input wire logic resetn, // reset, active low
  input wire logic [3:0] reg_addr, // address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic external_interrupt_input_0, // trigger
  input wire logic [7:0] motor_phase_output, // pins
  input wire logic [7:0] motor_phase_oe // pin enables
);
  // ----------
  // shadows
  // ----------
  logic en_q, tr_q;
  logic [1:0] ed_q;
  logic [7:0] ce_q, cs_q;
  wire w = reg_wr && en_q;
  wire x = external_interrupt_input_0;
  wire hit = en_q && (ed_q[0] && x && !tr_q || ed_q[1] && !x && tr_q);
  // module control and trigger copy
  always_ff @(posedge ref_clk) begin
    tr_q <= x;
    if (!resetn) begin
      {ed_q, en_q} <= 3'h2;
    end else if (reg_wr && reg_addr == ros_pkg::ADDR_MOD_CTRL) begin
      {ed_q, en_q} <= reg_wdata[2:0];
    end
  end
  // cutoff enables and state fields
  always_ff @(posedge ref_clk) begin
    if (!resetn || !en_q) begin
      ce_q <= 8'h00;
      cs_q <= 8'h00;
    end else if (w && reg_addr == ros_pkg::ADDR_CUT_ENA) begin
      ce_q <= reg_wdata;
    end else if (w && reg_addr == ros_pkg::ADDR_CUT_STATE) begin
      cs_q <= reg_wdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_trip(ok); hit && ok; endsequence
  a_cut_low: assert property (
    s_trip(ce_q[1] && cs_q[1:0] == ros_pkg::CUT_LOW)
    |-> ##2 motor_phase_oe[1] && !motor_phase_output[1])
    else $error("pin 1 not low after trip");
  a_cut_high: assert property (
    s_trip(ce_q[6] && cs_q[3:2] == ros_pkg::CUT_HIGH)
    |-> ##2 motor_phase_oe[6] && motor_phase_output[6])
    else $error("pin 6 not high after trip");
  a_cut_hiz: assert property (
    s_trip(ce_q[7] && cs_q[7:6] == ros_pkg::CUT_HIZ)
    |-> ##2 !motor_phase_oe[7]) else $error("pin 7 still driven");
  a_cut_void: assert property (
    s_trip(ce_q[4] && cs_q[5:4] == ros_pkg::CUT_OFF)
    |-> ##2 motor_phase_oe[4]) else $error("pin 4 cut though void");
  a_off_quiet: assert property (!en_q |=>
    motor_phase_oe == 8'h00 && motor_phase_output == 8'h00)
    else $error("pins active while disabled");
  a_off_regs: assert property (reg_rd && !en_q &&
    reg_addr <= ros_pkg::ADDR_CUT_STAT |=> reg_rdata == 8'h00)
    else $error("register readable while disabled");
  a_stat_bits: assert property (reg_rd &&
    reg_addr == ros_pkg::ADDR_CUT_STAT |=> (reg_rdata & 8'hfd) == 8'h00)
    else $error("status spare or clear bit set");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule
bind ros_steer ros_steer_chk u_ros_steer_chk (.ref_clk, .resetn,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .external_interrupt_input_0, .motor_phase_output, .motor_phase_oe);

/* File: verification/ros_drv_model.sv */
// Purpose: motor driver stage with current detector
// Assumes: bench commands overcurrent through trip
// Notes: released pins fall to the gate driver pull-down
`timescale 1ns/1ps
module ros_drv_model (
  input wire logic trip, // overcurrent request
  input wire logic [7:0] pin_q, // pin values
  input wire logic [7:0] pin_oe, // pin enables
  output logic fault, // cutoff trigger line
  output logic [7:0] level // resolved pin levels
);
  // ----------
  // detector and pins
  // ----------
  // hi-z pins read low, never the last driven value
  assign fault = trip;
  assign level = pin_oe & pin_q;
endmodule

/* File: verification/ros_steer_test.sv */
// Purpose: self-checking bench for ros_steer
// Assumes: rising trigger edge first, then falling and both, pins checked once settled
// Notes: reads queue their expectation for the monitor
`timescale 1ns/1ps
module ros_steer_test;
  // ----------
  // bench
  // ----------
  logic ref_clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic c1 = 1'b0, c3 = 1'b0, trip = 1'b0, fault;
  logic [3:0] a = 4'h0;
  logic [7:0] wd = 8'h00, rq, q, oe, lv, s, l, h, e;
  logic [7:0] eq[$];
  int bad_count = 0, tests_run = 0;
  ros_steer u_ros_steer (.ref_clk, .resetn, .reg_addr(a), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rq), .pwm_ch1(c1), .pwm_ch3(c3),
    .external_interrupt_input_0(fault), .motor_phase_output(q),
    .motor_phase_oe(oe));
  ros_drv_model u_ros_drv_model (.trip, .pin_q(q), .pin_oe(oe), .fault,
    .level(lv));
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic compare(input logic [7:0] ex, input logic [7:0] g);
    tests_run++;
    if (g !== ex) begin
      bad_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, ex, g);
    end
  endtask
  task automatic cmp_pin(input logic [7:0] eo, input logic [7:0] el);
    compare(eo, oe);
    compare(el, lv);
  endtask
  task automatic wr_reg(input logic [3:0] ad, input logic [7:0] d);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd_reg(input logic [3:0] ad, input logic [7:0] ex);
    a <= ad;
    rd <= 1'b1;
    eq.push_back(ex);
    @(posedge ref_clk);
    rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  function automatic logic [7:0] wav(input logic [7:0] sv, lo, hi);
    for (int i = 0; i < 8; i++) begin
      wav[i] = (i < 4 ? lo[i] : hi[i - 4]) ?
        ((sv[i] ? c3 : c1) ^ (i < 4 ? lo[i + 4] : hi[i])) :
        (i < 4 ? lo[i + 4] : hi[i]);
    end
  endfunction
  task automatic wrap_up;
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // read data lands one cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_d) compare(eq.pop_front(), rq);
    rd_d <= rd;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    wrap_up;
  end
  initial begin
    void'($urandom(36));
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    wr_reg(ros_pkg::ADDR_OUT_LOW, 8'h0f);
    rd_reg(ros_pkg::ADDR_OUT_LOW, 8'h00);
    cmp_pin(8'h00, 8'h00);
    // enable first, then source, low and high control
    wr_reg(ros_pkg::ADDR_MOD_CTRL, 8'h03);
    rd_reg(ros_pkg::ADDR_MOD_CTRL, 8'h03);
    for (int n = 0; n < 6; n++) begin
      s = 8'($urandom);
      l = 8'($urandom);
      h = 8'($urandom);
      c1 <= 1'($urandom);
      c3 <= 1'($urandom);
      // all phases off before the next pattern
      wr_reg(ros_pkg::ADDR_OUT_LOW, 8'h00);
      wr_reg(ros_pkg::ADDR_OUT_HIGH, 8'h00);
      wr_reg(ros_pkg::ADDR_SRC_SEL, s);
      cmp_pin(8'hff, 8'h00);
      wr_reg(ros_pkg::ADDR_OUT_LOW, l);
      wr_reg(ros_pkg::ADDR_OUT_HIGH, h);
      rd_reg(ros_pkg::ADDR_SRC_SEL, s);
      rd_reg(ros_pkg::ADDR_OUT_LOW, l);
      rd_reg(ros_pkg::ADDR_OUT_HIGH, h);
      cmp_pin(8'hff, wav(s, l, h));
    end
    // cutoff fields before enables; all four codes in use
    wr_reg(ros_pkg::ADDR_CUT_STATE, 8'h39);
    wr_reg(ros_pkg::ADDR_CUT_ENA, 8'hff);
    rd_reg(ros_pkg::ADDR_CUT_STATE, 8'h39);
    rd_reg(ros_pkg::ADDR_CUT_ENA, 8'hff);
    e = wav(s, l, h);
    cmp_pin(8'hff, e);
    trip <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cmp_pin(8'h7f, {2'b01, e[5:3], 3'b000});
    rd_reg(ros_pkg::ADDR_CUT_STAT, 8'h02);
    trip <= 1'b0;
    wr_reg(ros_pkg::ADDR_CUT_STAT, 8'h01);
    rd_reg(ros_pkg::ADDR_CUT_STAT, 8'h00);
    cmp_pin(8'hff, e);
    rd_reg(4'hf, 8'h00);
    // falling edge only: the rise must leave the flag low
    wr_reg(ros_pkg::ADDR_MOD_CTRL, 8'h05);
    trip <= 1'b1;
    rd_reg(ros_pkg::ADDR_MOD_CTRL, 8'h05);
    rd_reg(ros_pkg::ADDR_CUT_STAT, 8'h00);
    trip <= 1'b0;
    repeat (3) @(posedge ref_clk);
    cmp_pin(8'h7f, {2'b01, e[5:3], 3'b000});
    // both edges; an edge in the clear cycle keeps the flag
    wr_reg(ros_pkg::ADDR_MOD_CTRL, 8'h07);
    trip <= 1'b1;
    wr_reg(ros_pkg::ADDR_CUT_STAT, 8'h01);
    rd_reg(ros_pkg::ADDR_CUT_STAT, 8'h02);
    wr_reg(ros_pkg::ADDR_CUT_STAT, 8'h01);
    rd_reg(ros_pkg::ADDR_CUT_STAT, 8'h00);
    cmp_pin(8'hff, e);
    wr_reg(ros_pkg::ADDR_MOD_CTRL, 8'h00);
    rd_reg(ros_pkg::ADDR_SRC_SEL, 8'h00);
    cmp_pin(8'h00, 8'h00);
    @(posedge ref_clk);
    wrap_up;
  end
endmodule
